/* File: afe_cfg_regs.sv */
// analog configuration register bank with eeprom image bulk load and store
`timescale 1ns/1ps
`include "afe_cfg_map.svh"
// Functional notes
// R1: amp A bias bits 7:5, 000 ground
// R2: software avoids amp A bias code 101
// R3: amp B bias bits 4:0, 50 mV steps
// R4: bit 7 selects instrumentation topology
// R5: bit 6 routes amp A positive input
// R6: bit 5 routes amp B positive input
// R7: bit 4 turns analog switch on
// R8: bit 3 picks negative input source
// R9: bit 2 inserts pre-amplifier in path
// R10: bit 1 picks bias generator reference
// R11: bit 0 picks converter reference
// R12: keep-on mask one bit per block
// R13: idle converter powers down unmasked blocks
// R14: masked blocks stay powered when idle
// R15: all-zero mask enters power-down mode; logic enters it only while converter idle
// R16: eeprom image addresses 0x002 to 0x004
// R17: bulk load copies image, store writes back
// R18: all registers read/write, reset zero
module afe_cfg_regs (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_ee_req,
    input wire logic [10:0] i_ee_addr,
    input wire logic [7:0] i_ee_wdata,
    input wire afe_cfg_pkg::afe_eeprom_op_e i_eeprom_op_select,
    output logic [7:0] o_ee_rdata,
    output logic o_ee_hit,
    input wire logic i_conv_idle,
    output logic [2:0] o_amp_a_bias_code,
    output logic o_amp_a_bias_ground,
    output logic o_amp_a_bias_reserved,
    output logic [4:0] o_amp_b_bias_code,
    output logic o_amp_b_bias_ground,
    output logic o_front_amp_topology_sel,
    output logic o_amp_a_input_route,
    output logic o_amp_b_input_route,
    output logic o_analog_switch_on,
    output logic o_negative_input_route,
    output logic o_front_amp_path_enable,
    output logic o_bias_reference_sel,
    output logic o_converter_reference_sel,
    output logic [7:0] o_block_power_on,
    output logic o_power_down_mode
);
    logic [7:0] amp_bias_levels_reg;
    logic [7:0] analog_path_switches_reg;
    logic [7:0] block_keep_on_mask_reg;
    logic ee_load;
    logic ee_store;

    // eeprom engine walks the image; load writes here, store reads from here
    assign ee_load = i_ee_req && (i_eeprom_op_select == afe_cfg_pkg::AFE_OP_BULK_LOAD);
    assign ee_store = i_ee_req && (i_eeprom_op_select == afe_cfg_pkg::AFE_OP_BULK_STORE);

    // eeprom load beats a host write in the same cycle: restore wins
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            amp_bias_levels_reg <= `AFE_RST_AMP_BIAS; // [R18]
        end else if (ee_load && i_ee_addr == `AFE_EE_AMP_BIAS) begin
            amp_bias_levels_reg <= i_ee_wdata; // [R16] [R17]
        end else if (i_reg_wr && i_reg_addr == `AFE_OFS_AMP_BIAS) begin
            amp_bias_levels_reg <= i_reg_wdata; // [R18]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            analog_path_switches_reg <= `AFE_RST_PATH_SW; // [R18]
        end else if (ee_load && i_ee_addr == `AFE_EE_PATH_SW) begin
            analog_path_switches_reg <= i_ee_wdata; // [R16] [R17]
        end else if (i_reg_wr && i_reg_addr == `AFE_OFS_PATH_SW) begin
            analog_path_switches_reg <= i_reg_wdata; // [R18]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            block_keep_on_mask_reg <= `AFE_RST_KEEP_ON; // [R18]
        end else if (ee_load && i_ee_addr == `AFE_EE_KEEP_ON) begin
            block_keep_on_mask_reg <= i_ee_wdata; // [R16] [R17]
        end else if (i_reg_wr && i_reg_addr == `AFE_OFS_KEEP_ON) begin
            block_keep_on_mask_reg <= i_reg_wdata; // [R12] [R18]
        end
    end

    // host read port, one cycle latency; unmapped offsets read zero
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            case (i_reg_addr)
                `AFE_OFS_AMP_BIAS: o_reg_rdata <= amp_bias_levels_reg;
                `AFE_OFS_PATH_SW: o_reg_rdata <= analog_path_switches_reg;
                `AFE_OFS_KEEP_ON: o_reg_rdata <= block_keep_on_mask_reg;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // store side: image byte for the addressed slot, one cycle latency
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_ee_rdata <= 8'h00;
            o_ee_hit <= 1'b0;
        end else begin
            o_ee_hit <= ee_store && (i_ee_addr == `AFE_EE_AMP_BIAS ||
                i_ee_addr == `AFE_EE_PATH_SW || i_ee_addr == `AFE_EE_KEEP_ON); // [R17]
            case (i_ee_addr)
                `AFE_EE_AMP_BIAS: o_ee_rdata <= amp_bias_levels_reg; // [R16]
                `AFE_EE_PATH_SW: o_ee_rdata <= analog_path_switches_reg; // [R16]
                `AFE_EE_KEEP_ON: o_ee_rdata <= block_keep_on_mask_reg; // [R16]
                default: o_ee_rdata <= 8'h00;
            endcase
        end
    end

    // analog control decode, registered so outputs are glitch free
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_amp_a_bias_code <= 3'h0;
            o_amp_a_bias_ground <= 1'b1;
            o_amp_a_bias_reserved <= 1'b0;
            o_amp_b_bias_code <= 5'h00;
            o_amp_b_bias_ground <= 1'b1;
        end else begin
            o_amp_a_bias_code <= amp_bias_levels_reg[7:5]; // [R1]
            o_amp_a_bias_ground <= amp_bias_levels_reg[7:5] == 3'h0; // [R1]
            // code 101 has no defined level; flagged so analog side can hold ground
            o_amp_a_bias_reserved <= amp_bias_levels_reg[7:5] == `AFE_A_BIAS_RESERVED; // [R2]
            o_amp_b_bias_code <= amp_bias_levels_reg[4:0]; // [R3]
            o_amp_b_bias_ground <= amp_bias_levels_reg[4:0] == 5'h00; // [R3]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_front_amp_topology_sel <= 1'b0;
            o_amp_a_input_route <= 1'b0;
            o_amp_b_input_route <= 1'b0;
            o_analog_switch_on <= 1'b0;
            o_negative_input_route <= 1'b0;
            o_front_amp_path_enable <= 1'b0;
            o_bias_reference_sel <= 1'b0;
            o_converter_reference_sel <= 1'b0;
        end else begin
            o_front_amp_topology_sel <= analog_path_switches_reg[`AFE_BIT_TOPOLOGY]; // [R4]
            o_amp_a_input_route <= analog_path_switches_reg[`AFE_BIT_A_ROUTE]; // [R5]
            o_amp_b_input_route <= analog_path_switches_reg[`AFE_BIT_B_ROUTE]; // [R6]
            o_analog_switch_on <= analog_path_switches_reg[`AFE_BIT_ANA_SW]; // [R7]
            o_negative_input_route <= analog_path_switches_reg[`AFE_BIT_NEG_ROUTE]; // [R8]
            o_front_amp_path_enable <= analog_path_switches_reg[`AFE_BIT_PATH_EN]; // [R9]
            o_bias_reference_sel <= analog_path_switches_reg[`AFE_BIT_BIAS_REF]; // [R10]
            o_converter_reference_sel <= analog_path_switches_reg[`AFE_BIT_CONV_REF]; // [R11]
        end
    end

    afe_power_gate u_power_gate (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_conv_idle(i_conv_idle),
        .i_keep_on_mask(block_keep_on_mask_reg), // [R12]
        .o_block_power_on(o_block_power_on),
        .o_power_down_mode(o_power_down_mode)
    );

    a_write_readback: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R18]
        (i_reg_wr && i_reg_addr == `AFE_OFS_PATH_SW && !ee_load) ##1
        (i_reg_rd && i_reg_addr == `AFE_OFS_PATH_SW && !i_reg_wr && !ee_load)
        |=> (o_reg_rvalid && o_reg_rdata == $past(i_reg_wdata, 2)))
        else $error("path switch write not read back");
    a_bulk_load: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R17]
        (ee_load && i_ee_addr == `AFE_EE_KEEP_ON) |=>
        (block_keep_on_mask_reg == $past(i_ee_wdata)))
        else $error("bulk load did not update keep-on mask");
    a_bulk_store: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R16]
        (ee_store && i_ee_addr == `AFE_EE_AMP_BIAS) |=>
        (o_ee_hit && o_ee_rdata == $past(amp_bias_levels_reg)))
        else $error("bulk store returned wrong byte");
    a_a_bias_decode: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R1]
        ##1 (o_amp_a_bias_code == $past(amp_bias_levels_reg[7:5]) &&
        o_amp_a_bias_ground == ($past(amp_bias_levels_reg[7:5]) == 3'h0)))
        else $error("amp A bias decode wrong");
    a_b_bias_decode: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R3]
        ##1 (o_amp_b_bias_code == $past(amp_bias_levels_reg[4:0]) &&
        o_amp_b_bias_ground == ($past(amp_bias_levels_reg[4:0]) == 5'h00)))
        else $error("amp B bias decode wrong");
    a_route_bits: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R5]
        ##1 ({o_front_amp_topology_sel, o_amp_a_input_route, o_amp_b_input_route,
        o_analog_switch_on, o_negative_input_route, o_front_amp_path_enable,
        o_bias_reference_sel, o_converter_reference_sel} ==
        $past(analog_path_switches_reg)))
        else $error("path switch outputs disagree with register");
    a_reserved_flag: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R2]
        ##1 (o_amp_a_bias_reserved ==
        ($past(amp_bias_levels_reg[7:5]) == `AFE_A_BIAS_RESERVED)))
        else $error("amp A reserved code flag wrong");
    a_rvalid_idle: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R18]
        !i_reg_rd |=> !o_reg_rvalid)
        else $error("read valid without a read strobe");
    a_unmapped_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R18]
        (i_reg_rd && !(i_reg_addr inside {`AFE_OFS_AMP_BIAS, `AFE_OFS_PATH_SW,
        `AFE_OFS_KEEP_ON})) |=> (o_reg_rvalid && o_reg_rdata == 8'h00))
        else $error("unmapped offset did not read zero");
    a_reset_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R18]
        $fell(i_reset) |-> (amp_bias_levels_reg == `AFE_RST_AMP_BIAS &&
        analog_path_switches_reg == `AFE_RST_PATH_SW &&
        block_keep_on_mask_reg == `AFE_RST_KEEP_ON))
        else $error("registers not zero after reset");
    a_store_miss: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R17]
        !(ee_store && i_ee_addr inside {`AFE_EE_AMP_BIAS, `AFE_EE_PATH_SW,
        `AFE_EE_KEEP_ON}) |=> !o_ee_hit)
        else $error("store hit flagged for a foreign beat");
endmodule

/* File: afe_cfg_map.svh */
// register offsets, eeprom image addresses, field positions and reset values
`ifndef AFE_CFG_MAP_SVH
`define AFE_CFG_MAP_SVH
`define AFE_OFS_AMP_BIAS 8'h10
`define AFE_OFS_PATH_SW 8'h11
`define AFE_OFS_KEEP_ON 8'h12
`define AFE_EE_AMP_BIAS 11'h002
`define AFE_EE_PATH_SW 11'h003
`define AFE_EE_KEEP_ON 11'h004
`define AFE_RST_AMP_BIAS 8'h00
`define AFE_RST_PATH_SW 8'h00
`define AFE_RST_KEEP_ON 8'h00
`define AFE_BIT_TOPOLOGY 7
`define AFE_BIT_A_ROUTE 6
`define AFE_BIT_B_ROUTE 5
`define AFE_BIT_ANA_SW 4
`define AFE_BIT_NEG_ROUTE 3
`define AFE_BIT_PATH_EN 2
`define AFE_BIT_BIAS_REF 1
`define AFE_BIT_CONV_REF 0
`define AFE_A_BIAS_RESERVED 3'h5
`endif

/* File: afe_cfg_pkg.sv */
// types shared by the configuration register bank
package afe_cfg_pkg;
    typedef enum logic [1:0] {
        AFE_OP_READ_BYTE,
        AFE_OP_WRITE_BYTE,
        AFE_OP_BULK_LOAD,
        AFE_OP_BULK_STORE
    } afe_eeprom_op_e;
    typedef logic [7:0] afe_byte_t;
endpackage

/* File: afe_power_gate.sv */
// per-block power enables from the keep-on mask and converter idle state
`timescale 1ns/1ps
module afe_power_gate (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_conv_idle,
    input wire logic [7:0] i_keep_on_mask,
    output logic [7:0] o_block_power_on,
    output logic o_power_down_mode
);
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_blk
            always_ff @(posedge i_sys_clk) begin
                if (i_reset) begin
                    o_block_power_on[g] <= 1'b1;
                end else begin
                    // busy converter keeps all up; idle drops unmasked blocks
                    o_block_power_on[g] <= !i_conv_idle || i_keep_on_mask[g]; // [R13] [R14]
                end
            end
        end
    endgenerate

    // digital side never gates itself, so registers stay reachable
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_power_down_mode <= 1'b0;
        end else begin
            o_power_down_mode <= i_conv_idle && (i_keep_on_mask == 8'h00); // [R15]
        end
    end

    a_idle_gating: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R13]
        i_conv_idle |=> (o_block_power_on == $past(i_keep_on_mask)))
        else $error("idle power enables do not follow mask");
    a_busy_all_on: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R14]
        !i_conv_idle |=> (o_block_power_on == 8'hFF))
        else $error("blocks gated while converter busy");
    a_pd_mode: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R15]
        (i_conv_idle && i_keep_on_mask == 8'h00) |=> o_power_down_mode)
        else $error("power-down mode not entered");
endmodule

/* File: test_afe_cfg_regs.sv */
// self-checking bench for the analog configuration register bank
`timescale 1ns/1ps
`include "afe_cfg_map.svh"
module test_afe_cfg_regs;
    logic i_sys_clk, i_reset, i_reg_wr, i_reg_rd, i_ee_req, i_conv_idle;
    logic [7:0] i_reg_addr, i_reg_wdata, i_ee_wdata;
    logic [10:0] i_ee_addr;
    afe_cfg_pkg::afe_eeprom_op_e i_eeprom_op_select;
    logic [7:0] o_reg_rdata, o_ee_rdata, o_block_power_on;
    logic o_reg_rvalid, o_ee_hit, o_amp_a_bias_ground, o_amp_a_bias_reserved;
    logic [2:0] o_amp_a_bias_code;
    logic [4:0] o_amp_b_bias_code;
    logic o_amp_b_bias_ground, o_front_amp_topology_sel, o_amp_a_input_route;
    logic o_amp_b_input_route, o_analog_switch_on, o_negative_input_route;
    logic o_front_amp_path_enable, o_bias_reference_sel, o_converter_reference_sel;
    logic o_power_down_mode;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int j;
    integer seed;
    logic [7:0] m [3];
    logic [7:0] ofs [3] = '{`AFE_OFS_AMP_BIAS, `AFE_OFS_PATH_SW, `AFE_OFS_KEEP_ON};
    logic [10:0] eea [3] = '{`AFE_EE_AMP_BIAS, `AFE_EE_PATH_SW, `AFE_EE_KEEP_ON};

    afe_cfg_regs u_afe_cfg_regs (.i_sys_clk, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr,
        .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_ee_req, .i_ee_addr, .i_ee_wdata,
        .i_eeprom_op_select, .o_ee_rdata, .o_ee_hit, .i_conv_idle, .o_amp_a_bias_code,
        .o_amp_a_bias_ground, .o_amp_a_bias_reserved, .o_amp_b_bias_code,
        .o_amp_b_bias_ground, .o_front_amp_topology_sel, .o_amp_a_input_route,
        .o_amp_b_input_route, .o_analog_switch_on, .o_negative_input_route,
        .o_front_amp_path_enable, .o_bias_reference_sel, .o_converter_reference_sel,
        .o_block_power_on, .o_power_down_mode);

    function automatic logic [18:0] exp_dec(input logic [7:0] b, input logic [7:0] p);
        return {b[7:5], b[7:5] == 3'h0, b[7:5] == 3'h5, b[4:0], b[4:0] == 5'h00, p};
    endfunction
    function automatic logic [8:0] exp_pwr(input logic idle, input logic [7:0] mask);
        return {idle ? mask : 8'hFF, idle && mask == 8'h00};
    endfunction

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        for (int i = 0; i < 3; i++) if (a == ofs[i]) m[i] = d;
        @(negedge i_sys_clk);
        i_reg_wr = 1'b0;
    endtask
    // strobe left high so reads run back to back; the caller drops it
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(negedge i_sys_clk);
        chk("rvalid", 32'h1, 32'(o_reg_rvalid));
        chk("rdata", 32'(e), 32'(o_reg_rdata));
    endtask
    // decode and power outputs lag the register by one more edge
    task automatic settle_chk();
        @(negedge i_sys_clk);
        chk("decode", 32'(exp_dec(m[0], m[1])), 32'({o_amp_a_bias_code, o_amp_a_bias_ground,
            o_amp_a_bias_reserved, o_amp_b_bias_code, o_amp_b_bias_ground,
            o_front_amp_topology_sel, o_amp_a_input_route, o_amp_b_input_route,
            o_analog_switch_on, o_negative_input_route, o_front_amp_path_enable,
            o_bias_reference_sel, o_converter_reference_sel}));
        chk("power", 32'(exp_pwr(i_conv_idle, m[2])),
            32'({o_block_power_on, o_power_down_mode}));
        chk("rvalid_idle", 32'h0, 32'(o_reg_rvalid));
    endtask
    // leaves the strobe high so beats can run back to back
    task automatic ee(input logic [1:0] op, input logic [10:0] a, input logic [7:0] d);
        i_ee_req = 1'b1;
        i_eeprom_op_select = afe_cfg_pkg::afe_eeprom_op_e'(op);
        i_ee_addr = a;
        i_ee_wdata = d;
        @(negedge i_sys_clk);
    endtask

    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        {i_reg_wr, i_reg_rd, i_ee_req, i_conv_idle} = 4'h0;
        {i_reg_addr, i_reg_wdata, i_ee_wdata, i_ee_addr} = 35'h0;
        i_eeprom_op_select = afe_cfg_pkg::AFE_OP_READ_BYTE;
        i_reset = 1'b1;
        seed = 32'h4025adb2;
        m = '{default: 8'h00};
        repeat (8) @(negedge i_sys_clk);
        i_reset = 1'b0;
        for (int i = 0; i < 3; i++) rd_chk(ofs[i], 8'h00);
        i_reg_rd = 1'b0;
        settle_chk();
        for (int k = 0; k < 10; k++) begin
            wr(ofs[0], k < 8 ? {k[2:0], 5'($random(seed))} : (k == 8 ? 8'h1F : 8'hE0));
            settle_chk();
        end
        for (int k = 0; k < 8; k++) begin
            wr(ofs[1], 8'h01 << k);
            settle_chk();
        end
        // write then read on adjacent edges
        wr(ofs[1], 8'($random(seed)));
        rd_chk(ofs[1], m[1]);
        i_reg_rd = 1'b0;
        repeat (40) begin
            j = $unsigned($random(seed)) % 3;
            i_conv_idle = 1'($random(seed));
            wr(ofs[j], 8'($random(seed)));
            settle_chk();
            rd_chk(ofs[j], m[j]);
            i_reg_rd = 1'b0;
        end
        i_conv_idle = 1'b1;
        wr(ofs[2], 8'h00);
        settle_chk();
        wr(8'h13, 8'hA5);
        rd_chk(8'h13, 8'h00);
        i_reg_rd = 1'b0;
        for (int i = 0; i < 3; i++) begin
            m[i] = 8'($random(seed));
            ee(2'h2, eea[i], m[i]);
        end
        ee(2'h0, eea[0], ~m[0]);
        chk("ee_hit", 32'h0, 32'(o_ee_hit));
        ee(2'h1, eea[1], ~m[1]);
        chk("ee_hit", 32'h0, 32'(o_ee_hit));
        ee(2'h2, 11'h005, 8'h5A);
        for (int i = 0; i < 3; i++) begin
            ee(2'h3, eea[i], 8'h00);
            chk("ee_hit", 32'h1, 32'(o_ee_hit));
            chk("ee_rdata", 32'(m[i]), 32'(o_ee_rdata));
        end
        ee(2'h3, 11'h005, 8'h00);
        chk("ee_hit", 32'h0, 32'(o_ee_hit));
        i_ee_req = 1'b0;
        for (int i = 0; i < 3; i++) rd_chk(ofs[i], m[i]);
        i_reg_rd = 1'b0;
        settle_chk();
        close_out();
    end
endmodule
